// ==== common/cop_pkg.sv ====
package cop_pkg;
    // Extended configuration byte indices
    localparam logic [8:0] IDX_BARRIER_EN = 9'h01f;
    localparam logic [8:0] IDX_FLUSH_CACHE = 9'h020;
    localparam logic [8:0] IDX_PRELOAD_SIZE0 = 9'h016;
    localparam logic [8:0] IDX_PROD_STATE = 9'h085;
    localparam logic [8:0] IDX_FLUSH_POLICY = 9'h0f0;
    localparam logic [8:0] IDX_BARRIER_SUPPORT = 9'h1e6;
    localparam int PRELOAD_BYTES = 4;
    // Field positions
    localparam int FLUSH_BIT = 0;
    localparam int BARRIER_BIT = 1;
    localparam int BARRIER_EN_BIT = 0;
    localparam int FIFO_BIT = 0;
    // Production state report values
    localparam logic [7:0] PROD_NORMAL = 8'h00;
    localparam logic [7:0] PROD_MANUAL_PRE = 8'h01;
    localparam logic [7:0] PROD_AUTO_PRE = 8'h03;
    // Reset values
    localparam logic [7:0] PROD_STATE_RST = 8'h00;
    localparam logic [7:0] BARRIER_EN_RST = 8'h00;
    localparam logic [31:0] PRELOAD_RST = 32'h0000_0000;

    typedef struct packed {
        logic valid;
        logic write;
        logic [8:0] index;
        logic [7:0] data;
    } cop_csd_req_t;

    typedef struct packed {
        logic [31:0] addr;
        logic [7:0] data;
    } cop_entry_t;

    typedef enum logic [2:0] {
        PS_IDLE = 3'b001,
        PS_LOAD = 3'b010,
        PS_DONE = 3'b100
    } cop_ps_state_t;
endpackage

// ==== rtl/cop_cache_mem.sv ====
`timescale 1ns/1ps
module cop_cache_mem #(
    parameter int WIDTH = 40,
    parameter int DEPTH = 16,
    parameter int AW = 4
) (
    input wire logic clk_sys,
    input wire logic clkEn,
    input wire logic wrEn,
    input wire logic [AW-1:0] wrAddr,
    input wire logic [WIDTH-1:0] wrData,
    input wire logic [AW-1:0] rdAddr,
    output logic [WIDTH-1:0] rdData_q
);
    if (DEPTH < 2 || AW < 1 || (1 << AW) < DEPTH) begin : gSizeCheck
        $error("AW too narrow for DEPTH");
    end

    logic [WIDTH-1:0] store [DEPTH];

    // Read data always registered; no reset so it maps to block memory
    always_ff @(posedge clk_sys) begin
        if (clkEn) begin
            if (wrEn) begin
                store[wrAddr] <= wrData;
            end
            rdData_q <= store[rdAddr];
        end
    end
endmodule // cop_cache_mem

// ==== rtl/cop_core.sv ====
`timescale 1ns/1ps
// Overview of operation
// (RULE1) Flushing policy readable at byte 240
// (RULE2) In-order flag set: commit in arrival order
// (RULE3) Host may skip ordering-only barriers and flushes
// (RULE4) Barrier accepted without error under in-order policy; the code flags an error unless bit 0 of byte 31 (IDX_BARRIER_EN) is set
// (RULE5) Accepted barrier changes nothing in commit behaviour
// (RULE6) Flushing policy byte never changes
// (RULE7) Production state field at byte 133
// (RULE8) Manual and automatic production state methods
// (RULE9) Valid pre-load size write starts or restarts
// (RULE10) Host erases old data before pre-load size
// (RULE11) Host reprograms size after erase or repartition
// (RULE12) Host waits for stable supplies before commands
// (RULE13) Host restores core supply before wake command
// (RULE14) Barrier capability reported at byte 486
// (RULE15) In-order flag is bit 0, others zero
module cop_core #(
    parameter int DEPTH = 16,
    parameter bit FIFO_POLICY = 1'b1,
    parameter bit BARRIER_SUPPORT = 1'b1
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic clkEn,
    input wire cop_pkg::cop_csd_req_t csdReq,
    output logic csdAck_q,
    output logic csdErr_q,
    output logic [7:0] csdRdData_q,
    input wire logic cacheWrValid,
    input wire cop_pkg::cop_entry_t cacheWrEntry,
    output logic cacheWrReady_q,
    output logic commitValid_q,
    output cop_pkg::cop_entry_t commitEntry_q,
    input wire logic commitReady,
    output logic flushBusy_q,
    output logic prodActive_q,
    output logic prodRestart_q
);
    localparam int AW = $clog2(DEPTH);
    localparam int EW = $bits(cop_pkg::cop_entry_t);

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : gDepthCheck
        $error("DEPTH must be a power of two of at least 2");
    end

    // Policy bytes are elaboration constants: nothing can write them
    localparam logic [7:0] POLICY_BYTE = {7'h00, FIFO_POLICY}; // RULE6 RULE15
    localparam logic [7:0] SUPPORT_BYTE = {7'h00, BARRIER_SUPPORT}; // RULE14

    function automatic logic isPreloadIdx(input logic [8:0] idx);
        return idx >= cop_pkg::IDX_PRELOAD_SIZE0 &&
            idx < cop_pkg::IDX_PRELOAD_SIZE0 + 9'(cop_pkg::PRELOAD_BYTES);
    endfunction

    // Two-bit lane wraps on purpose; a wider difference would go negative
    function automatic logic [1:0] preloadLane(input logic [8:0] idx);
        return idx[1:0] - cop_pkg::IDX_PRELOAD_SIZE0[1:0];
    endfunction

    // Register file state
    logic csdAck_d, csdErr_d;
    logic [7:0] csdRdData_d;
    logic [7:0] prodState_q, prodState_d;
    logic [7:0] barrierEn_q, barrierEn_d;
    logic [31:0] preload_q, preload_d;
    logic flushReq, barrierReq, sizeWritten;

    // FIFO state
    logic [AW-1:0] wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
    logic [AW:0] count_q, count_d;
    logic commitValid_d, cacheWrReady_d, flushBusy_d;
    logic push, pop;

    // Production state process
    cop_pkg::cop_ps_state_t ps_q, ps_d;
    logic [31:0] loaded_q, loaded_d;
    logic prodRestart_d;

    always_comb begin
        logic [8:0] idx;
        idx = csdReq.index;
        csdAck_d = csdReq.valid;
        csdErr_d = 1'b0;
        csdRdData_d = csdRdData_q;
        prodState_d = prodState_q;
        barrierEn_d = barrierEn_q;
        preload_d = preload_q;
        flushReq = 1'b0;
        barrierReq = 1'b0;
        sizeWritten = 1'b0;
        if (csdReq.valid && !csdReq.write) begin
            case (idx)
                cop_pkg::IDX_FLUSH_POLICY: csdRdData_d = POLICY_BYTE; // RULE1
                cop_pkg::IDX_BARRIER_SUPPORT: csdRdData_d = SUPPORT_BYTE; // RULE14
                cop_pkg::IDX_PROD_STATE: csdRdData_d = prodState_q; // RULE7
                cop_pkg::IDX_BARRIER_EN: csdRdData_d = barrierEn_q;
                default: begin
                    if (isPreloadIdx(idx)) begin
                        csdRdData_d = preload_q[8*preloadLane(idx) +: 8];
                    end else begin
                        csdRdData_d = 8'h00;
                    end
                end
            endcase
        end else if (csdReq.valid) begin
            case (idx)
                // Read-only bytes keep their value; the write is flagged
                cop_pkg::IDX_FLUSH_POLICY, cop_pkg::IDX_BARRIER_SUPPORT: csdErr_d = 1'b1; // RULE6
                cop_pkg::IDX_PROD_STATE: begin
                    if (csdReq.data == cop_pkg::PROD_NORMAL || csdReq.data == cop_pkg::PROD_MANUAL_PRE ||
                        csdReq.data == cop_pkg::PROD_AUTO_PRE) begin
                        prodState_d = csdReq.data; // RULE7 RULE8
                    end else begin
                        csdErr_d = 1'b1;
                    end
                end
                cop_pkg::IDX_BARRIER_EN: barrierEn_d = {7'h00, csdReq.data[cop_pkg::BARRIER_EN_BIT]};
                cop_pkg::IDX_FLUSH_CACHE: begin
                    flushReq = csdReq.data[cop_pkg::FLUSH_BIT];
                    if (csdReq.data[cop_pkg::BARRIER_BIT]) begin
                        // Accepted only when supported and enabled at byte 31; the queue already drains in order
                        if (BARRIER_SUPPORT && barrierEn_q[cop_pkg::BARRIER_EN_BIT]) begin
                            barrierReq = 1'b1; // RULE4 RULE5
                        end else begin
                            csdErr_d = 1'b1;
                        end
                    end
                end
                default: begin
                    if (isPreloadIdx(idx)) begin
                        preload_d[8*preloadLane(idx) +: 8] = csdReq.data;
                        // Last byte completes the size; zero is not a valid size
                        if (idx == cop_pkg::IDX_PRELOAD_SIZE0 + 9'(cop_pkg::PRELOAD_BYTES - 1)) begin
                            if (preload_d != 32'h0000_0000) begin
                                sizeWritten = 1'b1; // RULE9
                            end else begin
                                csdErr_d = 1'b1;
                            end
                        end
                    end else begin
                        csdErr_d = 1'b1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            csdAck_q <= 1'b0;
            csdErr_q <= 1'b0;
            csdRdData_q <= 8'h00;
            prodState_q <= cop_pkg::PROD_STATE_RST;
            barrierEn_q <= cop_pkg::BARRIER_EN_RST;
            preload_q <= cop_pkg::PRELOAD_RST;
        end else if (clkEn) begin
            csdAck_q <= csdAck_d;
            csdErr_q <= csdErr_d;
            csdRdData_q <= csdRdData_d;
            prodState_q <= prodState_d;
            barrierEn_q <= barrierEn_d;
            preload_q <= preload_d;
        end
    end

    // Single queue, single read pointer: entries leave in arrival order
    always_comb begin
        push = cacheWrValid && cacheWrReady_q;
        pop = commitValid_q && commitReady; // RULE2
        wrPtr_d = push ? wrPtr_q + AW'(1) : wrPtr_q;
        rdPtr_d = pop ? rdPtr_q + AW'(1) : rdPtr_q;
        count_d = count_q + (AW+1)'(push) - (AW+1)'(pop);
        // One bubble after each pop lets the registered read catch up
        commitValid_d = !pop && count_q != '0;
        cacheWrReady_d = count_d < (AW+1)'(DEPTH);
        // Barrier does not touch the queue; only a flush waits for empty
        flushBusy_d = (flushBusy_q || flushReq) && count_d != '0; // RULE5
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
            commitValid_q <= 1'b0;
            cacheWrReady_q <= 1'b0;
            flushBusy_q <= 1'b0;
        end else if (clkEn) begin
            wrPtr_q <= wrPtr_d;
            rdPtr_q <= rdPtr_d;
            count_q <= count_d;
            commitValid_q <= commitValid_d;
            cacheWrReady_q <= cacheWrReady_d;
            flushBusy_q <= flushBusy_d;
        end
    end

    cop_cache_mem #(.WIDTH(EW), .DEPTH(DEPTH), .AW(AW)) uMem (
        .clk_sys(clk_sys),
        .clkEn(clkEn),
        .wrEn(push),
        .wrAddr(wrPtr_q),
        .wrData(cacheWrEntry),
        .rdAddr(rdPtr_d),
        .rdData_q(commitEntry_q)
    );

    // Production state process; a new size always restarts it
    always_comb begin
        ps_d = ps_q;
        loaded_d = loaded_q;
        prodRestart_d = 1'b0;
        case (ps_q)
            cop_pkg::PS_IDLE, cop_pkg::PS_LOAD, cop_pkg::PS_DONE: begin
                if (sizeWritten) begin
                    ps_d = cop_pkg::PS_LOAD; // RULE9
                    loaded_d = 32'h0000_0000;
                    prodRestart_d = 1'b1;
                end else if (ps_q == cop_pkg::PS_LOAD) begin
                    if (pop) begin
                        loaded_d = loaded_q + 32'h0000_0001;
                    end
                    if (prodState_q == cop_pkg::PROD_NORMAL) begin
                        ps_d = cop_pkg::PS_DONE; // RULE8
                    end else if (prodState_q == cop_pkg::PROD_AUTO_PRE && loaded_q >= preload_q) begin
                        ps_d = cop_pkg::PS_DONE; // RULE8
                    end
                end
            end
            default: ps_d = cop_pkg::PS_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ps_q <= cop_pkg::PS_IDLE;
            loaded_q <= 32'h0000_0000;
            prodActive_q <= 1'b0;
            prodRestart_q <= 1'b0;
        end else if (clkEn) begin
            ps_q <= ps_d;
            loaded_q <= loaded_d;
            prodActive_q <= ps_d == cop_pkg::PS_LOAD;
            prodRestart_q <= prodRestart_d;
        end
    end

    policy_read_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE1
        clkEn && csdReq.valid && !csdReq.write && csdReq.index == cop_pkg::IDX_FLUSH_POLICY
        |=> csdAck_q && csdRdData_q == {7'h00, FIFO_POLICY}) else $error("flush policy byte misread");
    policy_write_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE6
        clkEn && csdReq.valid && csdReq.write && csdReq.index == cop_pkg::IDX_FLUSH_POLICY
        |=> csdErr_q) else $error("policy write not refused");
    support_read_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE14
        clkEn && csdReq.valid && !csdReq.write && csdReq.index == cop_pkg::IDX_BARRIER_SUPPORT
        |=> csdRdData_q == {7'h00, BARRIER_SUPPORT}) else $error("barrier support misread");
    barrier_ok_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE4
        clkEn && csdReq.valid && csdReq.write && csdReq.index == cop_pkg::IDX_FLUSH_CACHE && FIFO_POLICY
        && BARRIER_SUPPORT && barrierEn_q[cop_pkg::BARRIER_EN_BIT] |=> csdAck_q && !csdErr_q)
        else $error("barrier flagged error");
    barrier_noop_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE5
        clkEn && barrierReq && !flushReq && !flushBusy_q |=> !flushBusy_q) else $error("barrier changed queue");
    commit_order_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE2
        clkEn && pop |=> rdPtr_q == $past(rdPtr_q) + AW'(1)) else $error("commit out of order");
    prod_write_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE7
        clkEn && csdReq.valid && csdReq.write && csdReq.index == cop_pkg::IDX_PROD_STATE
        && csdReq.data == cop_pkg::PROD_AUTO_PRE |=> prodState_q == cop_pkg::PROD_AUTO_PRE)
        else $error("production state not stored");
    restart_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE9
        clkEn && sizeWritten |=> (prodRestart_q && prodActive_q)
        and (clkEn && !sizeWritten |=> !prodRestart_q))
        else $error("pre-load size did not restart");
    auto_done_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE8
        clkEn && ps_q == cop_pkg::PS_LOAD && !sizeWritten && prodState_q == cop_pkg::PROD_AUTO_PRE
        && loaded_q >= preload_q |=> ps_q == cop_pkg::PS_DONE) else $error("auto mode did not finish");

    barrier_c: cover property (@(posedge clk_sys) disable iff (!reset_n) clkEn && barrierReq);
    flush_c: cover property (@(posedge clk_sys) disable iff (!reset_n) flushBusy_q ##[1:64] !flushBusy_q);
    full_c: cover property (@(posedge clk_sys) disable iff (!reset_n) !cacheWrReady_q && cacheWrValid);
    restart_c: cover property (@(posedge clk_sys) disable iff (!reset_n) prodActive_q && sizeWritten);
endmodule // cop_core

// ==== verif/cop_nv_sink.sv ====
`timescale 1ns/1ps
// Nonvolatile store behind the commit port; ready is either steady or one cycle in four
module cop_nv_sink (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic hold,
    input wire logic slow,
    input wire logic commitValid,
    input wire cop_pkg::cop_entry_t commitEntry,
    output logic commitReady
);
    logic [1:0] phase;
    cop_pkg::cop_entry_t got[$];

    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            commitReady <= 1'b0;
            phase <= 2'h0;
        end else begin
            phase <= phase + 2'h1;
            commitReady <= !hold && (!slow || phase == 2'h3);
            // Log what was really stored so the bench can check arrival order
            if (commitValid && commitReady) begin
                got.push_back(commitEntry);
            end
        end
    end
endmodule // cop_nv_sink

// ==== verif/cop_core_tb.sv ====
`timescale 1ns/1ps
module cop_core_tb;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic clkEn = 1'b1;
    logic cacheWrValid = 1'b0;
    logic hold = 1'b1;
    logic slow = 1'b0;
    cop_pkg::cop_csd_req_t csdReq = '0;
    cop_pkg::cop_entry_t cacheWrEntry = '0;
    cop_pkg::cop_entry_t commitEntry_q;
    logic csdAck_q, csdErr_q, cacheWrReady_q, commitValid_q, commitReady, flushBusy_q, prodActive_q, prodRestart_q;
    logic [7:0] csdRdData_q;
    logic e;
    logic [7:0] r;
    int err_count = 0;
    int n_compared = 0;
    int restarts = 0;

    initial begin
        forever #5 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        if (prodRestart_q === 1'b1) restarts <= restarts + 1;
    end

    cop_core #(.DEPTH(16), .FIFO_POLICY(1'b1), .BARRIER_SUPPORT(1'b1)) uut (
        .clk_sys(clk_sys), .reset_n(reset_n), .clkEn(clkEn), .csdReq(csdReq), .csdAck_q(csdAck_q),
        .csdErr_q(csdErr_q), .csdRdData_q(csdRdData_q), .cacheWrValid(cacheWrValid), .cacheWrEntry(cacheWrEntry),
        .cacheWrReady_q(cacheWrReady_q), .commitValid_q(commitValid_q), .commitEntry_q(commitEntry_q),
        .commitReady(commitReady), .flushBusy_q(flushBusy_q), .prodActive_q(prodActive_q),
        .prodRestart_q(prodRestart_q));

    cop_nv_sink sink (.clk_sys(clk_sys), .reset_n(reset_n), .hold(hold), .slow(slow), .commitValid(commitValid_q),
        .commitEntry(commitEntry_q), .commitReady(commitReady));

    task print_verdict;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task chk_bit(input string n, input logic x, input logic g);
        n_compared++;
        if (g !== x) begin
            err_count++;
            $display("[ERR] %s expected %b seen %b", n, x, g);
        end
    endtask

    task chk_val(input string n, input logic [39:0] x, input logic [39:0] g);
        n_compared++;
        if (g !== x) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", n, x, g);
        end
    endtask

    // Answer is registered on the taking edge and read at the next falling edge
    task csd(input logic w, input logic [8:0] idx, input logic [7:0] d);
        @(posedge clk_sys);
        csdReq <= '{1'b1, w, idx, d};
        @(posedge clk_sys);
        csdReq.valid <= 1'b0;
        @(negedge clk_sys);
        chk_bit("csdAck", 1'b1, csdAck_q);
        e = csdErr_q;
        r = csdRdData_q;
    endtask

    task wr(input logic [8:0] idx, input logic [7:0] d, input logic xe);
        csd(1'b1, idx, d);
        chk_bit("csdErr", xe, e);
    endtask

    task rd(input logic [8:0] idx, input logic [7:0] xd);
        csd(1'b0, idx, 8'h00);
        chk_bit("csdErr", 1'b0, e);
        chk_val("csdRdData", {32'h0, xd}, {32'h0, r});
    endtask

    // Size goes low byte first; only the last byte may be refused
    task size4(input logic [31:0] s, input logic xe);
        for (int k = 0; k < 4; k++) wr(cop_pkg::IDX_PRELOAD_SIZE0 + 9'(k), s[8*k +: 8], k == 3 ? xe : 1'b0);
        repeat (2) @(negedge clk_sys);
    endtask

    task push(input int i);
        int n;
        @(posedge clk_sys);
        cacheWrValid <= 1'b1;
        cacheWrEntry <= '{32'h10 + 32'(i), 8'ha0 + 8'(i)};
        for (n = 0; n < 100; n++) begin
            @(negedge clk_sys);
            if (cacheWrReady_q === 1'b1) break;
        end
        if (n == 100) begin
            err_count++;
            print_verdict;
        end
        @(posedge clk_sys);
        cacheWrValid <= 1'b0;
    endtask

    task wait_low(input bit sel);
        int n;
        for (n = 0; n < 400; n++) begin
            @(negedge clk_sys);
            if ((sel ? prodActive_q : flushBusy_q) === 1'b0) break;
        end
        if (n == 400) begin
            err_count++;
            print_verdict;
        end
    endtask

    initial begin
        repeat (4) @(posedge clk_sys);
        chk_bit("cacheWrReady", 1'b0, cacheWrReady_q);
        reset_n <= 1'b1;
        rd(cop_pkg::IDX_FLUSH_POLICY, 8'h01);
        wr(cop_pkg::IDX_FLUSH_POLICY, 8'hfe, 1'b1);
        rd(cop_pkg::IDX_FLUSH_POLICY, 8'h01);
        rd(cop_pkg::IDX_BARRIER_SUPPORT, 8'h01);
        wr(cop_pkg::IDX_BARRIER_SUPPORT, 8'h00, 1'b1);
        rd(9'h100, 8'h00);
        wr(9'h100, 8'h55, 1'b1);
        wr(cop_pkg::IDX_FLUSH_CACHE, 8'h02, 1'b1);
        wr(cop_pkg::IDX_BARRIER_EN, 8'h01, 1'b0);
        // Store stalled, so the barrier lands between queued entries
        for (int i = 0; i < 2; i++) push(i);
        wr(cop_pkg::IDX_FLUSH_CACHE, 8'h02, 1'b0);
        chk_bit("flushBusy", 1'b0, flushBusy_q);
        for (int i = 2; i < 4; i++) push(i);
        @(negedge clk_sys);
        chk_bit("commitValid", 1'b1, commitValid_q);
        chk_val("commitHead", {32'h10, 8'ha0}, commitEntry_q);
        wr(cop_pkg::IDX_FLUSH_CACHE, 8'h01, 1'b0);
        chk_bit("flushBusy", 1'b1, flushBusy_q);
        hold <= 1'b0;
        slow <= 1'b1;
        wait_low(1'b0);
        chk_val("stored", 40'd4, 40'(sink.got.size()));
        for (int i = 0; i < 4; i++) chk_val("order", {32'h10 + 32'(i), 8'ha0 + 8'(i)}, sink.got[i]);
        slow <= 1'b0;
        wr(cop_pkg::IDX_PROD_STATE, cop_pkg::PROD_MANUAL_PRE, 1'b0);
        rd(cop_pkg::IDX_PROD_STATE, cop_pkg::PROD_MANUAL_PRE);
        wr(cop_pkg::IDX_PROD_STATE, 8'h02, 1'b1);
        rd(cop_pkg::IDX_PROD_STATE, cop_pkg::PROD_MANUAL_PRE);
        size4(32'd5, 1'b0);
        chk_val("restarts", 40'd1, 40'(restarts));
        chk_bit("prodActive", 1'b1, prodActive_q);
        size4(32'h0300_0005, 1'b0);
        chk_val("restarts", 40'd2, 40'(restarts));
        rd(cop_pkg::IDX_PRELOAD_SIZE0 + 9'd3, 8'h03);
        wr(cop_pkg::IDX_PROD_STATE, cop_pkg::PROD_NORMAL, 1'b0);
        wait_low(1'b1);
        wr(cop_pkg::IDX_PROD_STATE, cop_pkg::PROD_AUTO_PRE, 1'b0);
        rd(cop_pkg::IDX_PROD_STATE, cop_pkg::PROD_AUTO_PRE);
        size4(32'd0, 1'b1);
        chk_val("restarts", 40'd2, 40'(restarts));
        size4(32'd2, 1'b0);
        chk_val("restarts", 40'd3, 40'(restarts));
        chk_bit("prodActive", 1'b1, prodActive_q);
        // Auto mode ends by itself once two entries reach the store
        for (int i = 4; i < 6; i++) push(i);
        wait_low(1'b1);
        // Core supply drops and returns: state must restart from its reset values
        @(posedge clk_sys);
        reset_n <= 1'b0;
        repeat (4) @(posedge clk_sys);
        chk_bit("cacheWrReady", 1'b0, cacheWrReady_q);
        reset_n <= 1'b1;
        rd(cop_pkg::IDX_PROD_STATE, cop_pkg::PROD_STATE_RST);
        rd(cop_pkg::IDX_FLUSH_POLICY, 8'h01);
        print_verdict;
    end
endmodule // cop_core_tb
